// *** logic/nvm_writer_map.svh ***
/*
  Offsets, field positions, memory locations and timing counts of the protected user-area writer.
  Assumes a 20 MHz system clock and word-aligned classic Wishbone register access.
*/
`ifndef NVM_WRITER_MAP_SVH
`define NVM_WRITER_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_SHADOW      8'h10
`define REG_FW_DATA     8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTRL_ADDR_GO    8
`define CTRL_ID_GO      9
`define CTRL_FW_GO      10
`define CTRL_INIT_GO    11
`define IRQ_DONE        0
`define IRQ_FAIL        1
`define IRQ_REFUSED     2
`define IRQ_CORRUPT     3
`define IRQ_WIDTH       4

// ----------------------------------------------------------------------------
// Memory locations
// ----------------------------------------------------------------------------
`define LOC_ADDR_LOW    5'h00
`define LOC_ADDR_HIGH   5'h01
`define LOC_ID_EXT      5'h02
`define LOC_FW_LOCK     5'h0C
`define FW_LOCK_BIT     1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ          20000000
`define PROG_TIME_US    12500
`define READ_TIME_NS    110
`define PROG_CYCLES     ((`PROG_TIME_US * (`CLK_HZ / 1000000)))
`define READ_CYCLES     ((`READ_TIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`endif

// *** logic/nvm_writer_pkg.sv ***
/*
  Types of the protected user-area writer.
  Assumes nothing of its surroundings.
*/
package nvm_writer_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_FLAG_SET = 4'b0001,
    ST_FLAG_CHK = 4'b0010,
    ST_DATA_WR  = 4'b0011,
    ST_DATA_CHK = 4'b0100,
    ST_FLAG_CLR = 4'b0101,
    ST_FLAG_CK0 = 4'b0110,
    ST_INIT_RD  = 4'b0111,
    ST_FW_WR    = 4'b1000
  } seq_state_t;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_FLAG_READ = 2'b10,
    OP_FLAG_PROG = 2'b11
  } mem_op_t;

endpackage

// *** logic/nvm_cell_array.sv ***
/*
  Behavioural non-volatile array: user block, firmware block and one transaction flag, in flip-flops.
  Assumes one operation at a time; programming and reading take fixed cycle counts.
*/
`timescale 1ns/10ps
`include "nvm_writer_map.svh"

module nvm_cell_array #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
  parameter int unsigned READ_CYCLES = `READ_CYCLES
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Operation request
  input  wire logic                    start_i,
  input  wire nvm_writer_pkg::mem_op_t op_i,
  input  wire logic [4:0]              loc_i,
  input  wire logic [3:0]              wdata_i,
  input  wire logic                    flag_i,
  // Result
  output logic                         done_o,
  output logic [3:0]                   rdata_o,
  output logic                         flag_o
);

  initial begin
    if (PROG_CYCLES < 1 || READ_CYCLES < 1) begin
      $error("nvm_cell_array: cycle counts must be at least one");
    end
  end

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  // Cells are not reset: they model memory that survives power loss.
  logic [3:0]  cell_q [0:31];
  logic        flag_cell_q;
  logic [31:0] cnt_q;
  logic        busy_q;
  nvm_writer_pkg::mem_op_t op_q;
  logic [4:0]  loc_q;
  logic [3:0]  wdata_q;
  logic        wflag_q;

  wire         last = (cnt_q == 32'h0000_0001);
  wire         prog = (op_q == nvm_writer_pkg::OP_PROG) || (op_q == nvm_writer_pkg::OP_FLAG_PROG);
  wire  [31:0] load = (op_i == nvm_writer_pkg::OP_PROG || op_i == nvm_writer_pkg::OP_FLAG_PROG) ?
                      32'(PROG_CYCLES) : 32'(READ_CYCLES);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q  <= 1'b0;
      cnt_q   <= 32'h0000_0000;
      done_o  <= 1'b0;
      rdata_o <= 4'h0;
      flag_o  <= 1'b0;
      op_q    <= nvm_writer_pkg::OP_READ;
      loc_q   <= 5'h00;
      wdata_q <= 4'h0;
      wflag_q <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (!busy_q && start_i) begin
        busy_q  <= 1'b1;
        cnt_q   <= load;
        op_q    <= op_i;
        loc_q   <= loc_i;
        wdata_q <= wdata_i;
        wflag_q <= flag_i;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 32'h0000_0001;
        if (last) begin
          busy_q  <= 1'b0;
          done_o  <= 1'b1;
          rdata_o <= cell_q[loc_q];
          flag_o  <= flag_cell_q;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && busy_q && last && prog) begin
      if (op_q == nvm_writer_pkg::OP_FLAG_PROG) begin
        flag_cell_q <= wflag_q;
      end else begin
        cell_q[loc_q] <= wdata_q;
      end
    end
  end

endmodule

// *** logic/wb_regs.sv ***
/*
  Classic Wishbone slave decode for the writer: one aligned word per register, ack one cycle after request.
  Assumes the master holds the request until ack and drops it for at least a cycle after.
*/
`timescale 1ns/10ps
`include "nvm_writer_map.svh"

module wb_regs (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  // Decoded strobes
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       adr_o,
  output logic             lane0_o,
  output logic             lane1_o
);

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
    end
  end

  // Writes take effect at the acknowledging edge, the only edge the master treats as final.
  assign wr_o    = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && ce_i;
  assign rd_o    = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i && ce_i;
  assign adr_o   = {wb_adr_i[7:2], 2'b00};
  assign lane0_o = wb_sel_i[0];
  assign lane1_o = wb_sel_i[1];

endmodule

// *** logic/protected_user_area_nvm_writer.sv ***
/*
  Protected user-area writer: wraps each user-block write in set/verify/clear/verify steps on a
  transaction flag, checks the flag at initialization and zeroes the node-number shadow if it is set.
  Assumes a 20 MHz clock, a synchronous active-high reset and a classic Wishbone master.
*/
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "nvm_writer_map.svh"


module protected_user_area_nvm_writer #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
  parameter int unsigned READ_CYCLES = `READ_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Status
  output logic             busy_o,
  output logic             irq_o,
  output logic [4:0]       node_number_o,
  output logic [3:0]       id_extension_one_field_o,
  output logic             ab_select_o
);

  initial begin
    if (PROG_CYCLES < 1 || READ_CYCLES < 1) begin
      $error("protected_user_area_nvm_writer: cycle counts must be at least one");
    end
  end

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_adr;
  logic       lane0;
  logic       lane1;

  wb_regs u_bus (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wr_o     (bus_wr),
    .rd_o     (bus_rd),
    .adr_o    (bus_adr),
    .lane0_o  (lane0),
    .lane1_o  (lane1)
  );

  // --------------------------------------------------------------------------
  // Memory array
  // --------------------------------------------------------------------------
  logic                    mem_start;
  nvm_writer_pkg::mem_op_t mem_op;
  logic [4:0]              mem_loc;
  logic [3:0]              mem_wdata;
  logic                    mem_flag;
  logic                    mem_done;
  logic [3:0]              mem_rdata;
  logic                    mem_rflag;

  nvm_cell_array #(
    .PROG_CYCLES (PROG_CYCLES),
    .READ_CYCLES (READ_CYCLES)
  ) u_array (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (mem_start),
    .op_i    (mem_op),
    .loc_i   (mem_loc),
    .wdata_i (mem_wdata),
    .flag_i  (mem_flag),
    .done_o  (mem_done),
    .rdata_o (mem_rdata),
    .flag_o  (mem_rflag)
  );

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  wire hit_ctrl = (bus_adr == `REG_CTRL);
  wire hit_ist  = (bus_adr == `REG_IRQ_STATUS);
  wire hit_imsk = (bus_adr == `REG_IRQ_MASK);
  wire hit_fwd  = (bus_adr == `REG_FW_DATA);
  wire ctrl_wr  = bus_wr && hit_ctrl && lane0 && lane1;
  wire go_addr  = ctrl_wr && wb_dat_i[`CTRL_ADDR_GO];
  wire go_id    = ctrl_wr && wb_dat_i[`CTRL_ID_GO];
  wire go_fw    = ctrl_wr && wb_dat_i[`CTRL_FW_GO];
  wire go_init  = ctrl_wr && wb_dat_i[`CTRL_INIT_GO];

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  nvm_writer_pkg::seq_state_t state_q;
  nvm_writer_pkg::seq_state_t state_d;
  logic [4:0]              wr_value_q;
  logic                    wr_is_id_q;
  logic [1:0]              step_q;
  logic                    issued_q;
  logic [4:0]              node_q;
  logic [3:0]              idext_q;
  logic                    fw_lock_q;
  logic                    corrupt_q;
  logic                    fail_q;
  logic [3:0]              fw_loc_q;
  logic [3:0]              fw_data_q;
  logic [`IRQ_WIDTH-1:0]   irq_st_q;
  logic [`IRQ_WIDTH-1:0]   irq_mask_q;
  logic [`IRQ_WIDTH-1:0]   irq_set;

  wire idle      = (state_q == nvm_writer_pkg::ST_IDLE);
  wire any_go    = go_addr || go_id;
  wire fw_refuse = go_fw && idle && fw_lock_q;
  wire step_done = issued_q && mem_done;

  // Location and nibble for the current data step of a user write.
  wire [4:0] data_loc  = wr_is_id_q ? `LOC_ID_EXT :
                         (step_q == 2'd0) ? `LOC_ADDR_LOW : `LOC_ADDR_HIGH;
  wire [3:0] data_nib  = wr_is_id_q ? wr_value_q[3:0] :
                         (step_q == 2'd0) ? wr_value_q[3:0] : {3'b000, wr_value_q[4]};
  wire       data_last = wr_is_id_q || (step_q == 2'd1);
  wire [3:0] data_mask = (!wr_is_id_q && step_q == 2'd1) ? 4'h1 : 4'hF;
  wire       data_ok   = ((mem_rdata & data_mask) == data_nib);
  wire [4:0] init_loc  = (step_q == 2'd0) ? `LOC_ADDR_LOW :
                         (step_q == 2'd1) ? `LOC_ADDR_HIGH :
                         (step_q == 2'd2) ? `LOC_ID_EXT : `LOC_FW_LOCK;

  always_comb begin
    state_d   = state_q;
    mem_start = 1'b0;
    mem_op    = nvm_writer_pkg::OP_READ;
    mem_loc   = 5'h00;
    mem_wdata = 4'h0;
    mem_flag  = 1'b0;
    unique case (state_q)
      nvm_writer_pkg::ST_IDLE: begin
        if (go_init) begin
          state_d = nvm_writer_pkg::ST_INIT_RD;
        end else if (any_go) begin
          state_d = nvm_writer_pkg::ST_FLAG_SET;
        end else if (go_fw && !fw_lock_q) begin
          state_d = nvm_writer_pkg::ST_FW_WR;
        end
      end
      nvm_writer_pkg::ST_FLAG_SET: begin
        mem_op    = nvm_writer_pkg::OP_FLAG_PROG;
        mem_flag  = 1'b1;
        mem_start = !issued_q;
        if (step_done) state_d = nvm_writer_pkg::ST_FLAG_CHK;
      end
      nvm_writer_pkg::ST_FLAG_CHK: begin
        mem_op    = nvm_writer_pkg::OP_FLAG_READ;
        mem_start = !issued_q;
        if (step_done) begin
          state_d = mem_rflag ? nvm_writer_pkg::ST_DATA_WR : nvm_writer_pkg::ST_IDLE;
        end
      end
      nvm_writer_pkg::ST_DATA_WR: begin
        mem_op    = nvm_writer_pkg::OP_PROG;
        mem_loc   = data_loc;
        mem_wdata = data_nib;
        mem_start = !issued_q;
        if (step_done) state_d = nvm_writer_pkg::ST_DATA_CHK;
      end
      nvm_writer_pkg::ST_DATA_CHK: begin
        mem_op    = nvm_writer_pkg::OP_READ;
        mem_loc   = data_loc;
        mem_start = !issued_q;
        if (step_done) begin
          if (!data_ok) begin
            state_d = nvm_writer_pkg::ST_IDLE;
          end else if (data_last) begin
            state_d = nvm_writer_pkg::ST_FLAG_CLR;
          end else begin
            state_d = nvm_writer_pkg::ST_DATA_WR;
          end
        end
      end
      nvm_writer_pkg::ST_FLAG_CLR: begin
        mem_op    = nvm_writer_pkg::OP_FLAG_PROG;
        mem_flag  = 1'b0;
        mem_start = !issued_q;
        if (step_done) state_d = nvm_writer_pkg::ST_FLAG_CK0;
      end
      nvm_writer_pkg::ST_FLAG_CK0: begin
        mem_op    = nvm_writer_pkg::OP_FLAG_READ;
        mem_start = !issued_q;
        if (step_done) state_d = nvm_writer_pkg::ST_IDLE;
      end
      nvm_writer_pkg::ST_INIT_RD: begin
        mem_op    = (step_q == 2'd0) ? nvm_writer_pkg::OP_FLAG_READ : nvm_writer_pkg::OP_READ;
        mem_loc   = init_loc;
        mem_start = !issued_q;
        if (step_done && step_q == 2'd3) state_d = nvm_writer_pkg::ST_IDLE;
      end
      nvm_writer_pkg::ST_FW_WR: begin
        mem_op    = nvm_writer_pkg::OP_PROG;
        mem_loc   = {1'b0, fw_loc_q} + 5'h08;
        mem_wdata = fw_data_q;
        mem_start = !issued_q;
        if (step_done) state_d = nvm_writer_pkg::ST_IDLE;
      end
      default: begin
        state_d = nvm_writer_pkg::ST_IDLE;
      end
    endcase
  end

  // Event bits for the sticky status.
  wire wr_end   = step_done && ((state_q == nvm_writer_pkg::ST_FLAG_CK0) ||
                  (state_q == nvm_writer_pkg::ST_FLAG_CHK && !mem_rflag) ||
                  (state_q == nvm_writer_pkg::ST_DATA_CHK && !data_ok));
  wire wr_bad   = step_done && ((state_q == nvm_writer_pkg::ST_FLAG_CK0 && mem_rflag) ||
                  (state_q == nvm_writer_pkg::ST_FLAG_CHK && !mem_rflag) ||
                  (state_q == nvm_writer_pkg::ST_DATA_CHK && !data_ok));
  wire init_bad = step_done && (state_q == nvm_writer_pkg::ST_INIT_RD) && (step_q == 2'd0) && mem_rflag;

  always_comb begin
    irq_set               = '0;
    irq_set[`IRQ_DONE]    = wr_end && !wr_bad;
    irq_set[`IRQ_FAIL]    = wr_bad;
    irq_set[`IRQ_REFUSED] = fw_refuse || (any_go && !idle);
    irq_set[`IRQ_CORRUPT] = init_bad;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= nvm_writer_pkg::ST_IDLE;
      issued_q <= 1'b0;
      step_q   <= 2'd0;
    end else if (ce_i) begin
      state_q  <= state_d;
      issued_q <= (state_d == state_q) && (issued_q || mem_start) && !step_done;
      if (state_d == nvm_writer_pkg::ST_IDLE) begin
        step_q <= 2'd0;
      end else if (step_done && state_q == nvm_writer_pkg::ST_INIT_RD) begin
        step_q <= step_q + 2'd1;
      end else if (step_done && state_q == nvm_writer_pkg::ST_DATA_CHK && !data_last) begin
        step_q <= step_q + 2'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_value_q <= 5'h00;
      wr_is_id_q <= 1'b0;
      fw_loc_q   <= 4'h0;
      fw_data_q  <= 4'h0;
    end else if (ce_i && idle && ctrl_wr) begin
      wr_value_q <= wb_dat_i[4:0];
      wr_is_id_q <= go_id && !go_addr;
      fw_loc_q   <= wb_dat_i[7:4];
      fw_data_q  <= wb_dat_i[3:0];
    end
  end

  // Shadow registers follow the array at init and on a verified write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      node_q    <= 5'h00;
      idext_q   <= 4'h0;
      fw_lock_q <= 1'b0;
      corrupt_q <= 1'b0;
      fail_q    <= 1'b0;
    end else if (ce_i) begin
      if (step_done && state_q == nvm_writer_pkg::ST_INIT_RD) begin
        // The flag read of step 0 also returns location 0, so the low nibble is taken there.
        unique case (step_q)
          2'd0: begin
            corrupt_q   <= mem_rflag;
            node_q[3:0] <= mem_rflag ? 4'h0 : mem_rdata;
          end
          2'd1: node_q[4] <= corrupt_q ? 1'b0 : mem_rdata[0];
          2'd2: idext_q <= mem_rdata;
          2'd3: fw_lock_q <= mem_rdata[`FW_LOCK_BIT];
        endcase
      end
      if (step_done && state_q == nvm_writer_pkg::ST_FLAG_CK0 && !mem_rflag) begin
        corrupt_q <= 1'b0;
        if (wr_is_id_q) idext_q <= wr_value_q[3:0];
        else node_q <= wr_value_q;
      end
      if (wr_end) fail_q <= wr_bad;
    end
  end

  // Set wins over the write-one clear.
  wire [`IRQ_WIDTH-1:0] irq_clr = (bus_wr && hit_ist && lane0) ? wb_dat_i[`IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q   <= '0;
      irq_mask_q <= '0;
    end else if (ce_i) begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      if (bus_wr && hit_imsk && lane0) irq_mask_q <= wb_dat_i[`IRQ_WIDTH-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Read data and outputs
  // --------------------------------------------------------------------------
  wire [31:0] status_word = {24'h0000_00, 1'b0, fw_lock_q, fail_q, corrupt_q, state_q};
  wire [31:0] rd_mux = (bus_adr == `REG_CTRL)       ? {27'h000_0000, wr_value_q} :
                       (bus_adr == `REG_STATUS)     ? status_word :
                       hit_ist                      ? {28'h000_0000, irq_st_q} :
                       hit_imsk                     ? {28'h000_0000, irq_mask_q} :
                       (bus_adr == `REG_SHADOW)     ? {23'h00_0000, idext_q, node_q} :
                       hit_fwd                      ? {24'h00_0000, fw_loc_q, fw_data_q} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) ? rd_mux : 32'h0000_0000;
    end
  end

  assign busy_o                   = !idle;
  assign irq_o                    = |(irq_st_q & irq_mask_q);
  assign node_number_o            = node_q;
  assign id_extension_one_field_o = idext_q;
  assign ab_select_o              = idext_q[3];

endmodule

// *** testbench/nvm_writer_chk.sv ***
/*
  Checker of the writer's bus answer, busy and shadow outputs.
  Assumes it is bound to the top module and that ce_i stays high.
*/
`timescale 1ns/10ps
module nvm_writer_chk (
  // Watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        busy_o,
  input wire logic [4:0]  node_number_o,
  input wire logic [3:0]  id_extension_one_field_o,
  input wire logic        ab_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Initialization loads the shadows while busy, so the hold checks skip a run started by it.
  logic init_run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_run_q <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_dat_i[11] && !busy_o) begin
      init_run_q <= 1'b1;
    end else if (!busy_o) begin
      init_run_q <= 1'b0;
    end
  end
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_AB_SEL: assert property (ab_select_o == id_extension_one_field_o[3])
    else $error("select bit differs");
  AST_GO: assert property (wb_cyc_i && wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[8] && !busy_o |=> busy_o)
    else $error("write not started");
  // Even the shortest sequence, the four reads of initialization, holds busy for at least 8 cycles.
  AST_BUSY_MIN: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("sequence too short");
  AST_NODE_HOLD: assert property (busy_o && !init_run_q |=> busy_o -> $stable(node_number_o))
    else $error("node shadow moved while busy");
  AST_ID_HOLD: assert property (busy_o && !init_run_q |=> busy_o -> $stable(id_extension_one_field_o))
    else $error("id shadow moved while busy");
endmodule

// *** testbench/wb_host.sv ***
/*
  Classic Wishbone host standing in for software.
  Assumes the caller enters access just after a rising edge.
*/
`timescale 1ns/10ps
module wb_host (
  // Bus
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0000_0000;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    // Released data is inverted so a slave sampling it late sees garbage.
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule

// *** testbench/tb_protected_user_area_nvm_writer.sv ***
/*
  Self-checking bench of the protected user-area writer.
  Assumes short programming and read counts set through the parameters.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_protected_user_area_nvm_writer;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, we, ack, busy, irq, ab;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [4:0]  node, v;
  logic [3:0]  idx, w;
  logic [31:0] exp_q[$], msk_q[$];
  int          mismatches = 0;
  int          n_compared = 0;
  initial forever #25 clk_i = ~clk_i;
  wb_host host_u (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat));
  protected_user_area_nvm_writer #(.PROG_CYCLES(20), .READ_CYCLES(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy), .irq_o(irq), .node_number_o(node),
    .id_extension_one_field_o(idx), .ab_select_o(ab));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host_u.access(1'b0, a, 32'h0000_0000);
  endtask
  task automatic idle();
    wait (busy === 1'b0);
    @(posedge clk_i);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
    `CHK("rdata", exp_q[0], rdat & msk_q[0])
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end
  initial begin
    #(4000 * 50);
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(32'h718f));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    v = 5'($urandom_range(31, 1));
    w = 4'($urandom_range(15, 8));
    wr(8'h0C, 32'h0000_0004);
    wr(8'h00, {23'h0, 1'b1, 3'h0, v});
    `CHK("busy", 1'b1, busy)
    wr(8'h00, {22'h0, 1'b1, 5'h0, w});
    `CHK("irq", 1'b1, irq)
    idle();
    `CHK("node", v, node)
    rd(8'h08, 32'h0000_0005, 32'h0000_000F);
    rd(8'h04, 32'h0000_0000, 32'h0000_003F);
    wr(8'h08, 32'h0000_0004);
    `CHK("irq", 1'b0, irq)
    $display("test node write done");
    wr(8'h00, {22'h0, 1'b1, 5'h0, w});
    idle();
    `CHK("idext", w, idx)
    `CHK("absel", w[3], ab)
    rd(8'h10, {23'h0, w, v}, 32'h0000_01FF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'h00, 32'h0000_0442);
    idle();
    rd(8'h14, 32'h0000_0042, 32'h0000_00FF);
    $display("test id write done");
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h00, 32'h0000_0800);
    idle();
    `CHK("node", v, node)
    rd(8'h04, 32'h0000_0000, 32'h0000_0010);
    rd(8'h04, 32'h0000_0040, 32'h0000_0040);
    wr(8'h00, 32'h0000_0442);
    `CHK("busy", 1'b0, busy)
    rd(8'h08, 32'h0000_0004, 32'h0000_0004);
    $display("test clean init done");
    wr(8'h00, {23'h0, 1'b1, 3'h0, ~v});
    repeat (32) @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h0C, 32'h0000_0008);
    wr(8'h00, 32'h0000_0800);
    idle();
    `CHK("node", 5'h00, node)
    `CHK("irq", 1'b1, irq)
    rd(8'h04, 32'h0000_0010, 32'h0000_0010);
    $display("test interrupted write done");
    wr(8'h00, {23'h0, 1'b1, 3'h0, v});
    idle();
    `CHK("node", v, node)
    rd(8'h04, 32'h0000_0000, 32'h0000_0030);
    $display("test rewrite done");
    final_report();
  end
endmodule
bind protected_user_area_nvm_writer nvm_writer_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .busy_o(busy_o), .node_number_o(node_number_o),
  .id_extension_one_field_o(id_extension_one_field_o), .ab_select_o(ab_select_o));
